// ### logic/terminal_router_regs.svh
// register offsets, reset values, field positions and route codes
// assumes byte offsets into the function's configuration space
`ifndef TERMINAL_ROUTER_REGS_SVH
`define TERMINAL_ROUTER_REGS_SVH
`define ROUTE_SEL_OFFSET 8'h8C
`define ROUTE_SEL_RESET 28'h000_0000
`define ROUTE_SEL_RO_MSB 31
`define ROUTE_SEL_RO_LSB 28
`define ROUTE_FIELD_W 4
`define ROUTE_PIN_COUNT 7
`define SYNC_W 9
`define SUPPLY0_BIT 7
`define SUPPLY1_BIT 8
`define CODE_GPI 4'h0
`define CODE_GPO 4'h1
`define CODE_LOW_OR_INTA 4'h2
`define CODE_VIDEO_STAT 4'h6
`define CODE_VIDEO_SEL 4'h7
`define CODE_AUDIO_PWM 4'h8
`define CODE_LED_OR_RING 4'hC
`define CODE_LED_P4 4'hD
`define CODE_EVENT 4'hE
`define CODE_LAST 4'hF
`endif

// ### logic/terminal_router_pkg.sv
// types shared by the terminal router
// assumes terminal_router_regs.svh is on the include path
package terminal_router_pkg;
    typedef struct packed
    {
        logic [15:0] irq;
        logic inta;
        logic gp_output_zero;
        logic gp_output_one;
        logic gp_output_three;
        logic bus_lock;
        logic card_audio_pwm;
        logic socket_activity_led;
        logic general_purpose_event;
        logic video_port_status;
        logic video_port_select0;
        logic low_power_state_flag;
        logic ring_indicate_out;
        logic diag_test;
    } src_s;
    typedef struct packed
    {
        logic oe;
        logic val;
    } pin_drv_s;
    typedef struct packed
    {
        logic [7:0] addr;
        logic [3:0] byte_en;
        logic wr;
        logic rd;
        logic [31:0] wdata;
    } cfg_req_s;
endpackage

// ### logic/terminal_router.sv
// multifunction terminal router: routing register and per-terminal selection
// assumes a config-space port on clk_in, sources and loader on the same clock
// Behaviour
// - after reset terminals zero to two, four and five are general inputs, three and six undriven, all fields zero
// - routing register may be loaded from serial eeprom instead of default
// - bits 31 to 28 read zero and ignore writes
// - terminal six field 27:24, zero reserved, 1000-1111 select irq 8-15
// - terminal five field 23:20 codes: input four, pwm, irq, led, test, event
// - terminal four field 19:16 codes: gpio three, lock, irq, video, pwm, ring, led, event
// - both supply straps high: terminal four is scl, terminal one sda
// - terminal three field 15:12, same mapping as terminal six
// - terminal two field 11:8 codes: input two, pwm, irq, ring, flag, event, irq7
// - terminal one field 7:4 codes: gpio one, flag, irq, video, pwm, led, event
// - terminal zero as terminal one but gpio zero and inta on 0010
// - ring indicate routes to terminal two or four only when enabled
`include "terminal_router_regs.svh"
module terminal_router
(
    input wire logic clk_in,
    input wire logic rst_in,
    input terminal_router_pkg::cfg_req_s cfg_req_in,
    output logic [31:0] cfg_rdata_out,
    input wire logic eeprom_load_valid_in,
    input wire logic [31:0] eeprom_load_data_in,
    input terminal_router_pkg::src_s internal_src_in,
    input wire logic ring_output_enable_in,
    input wire logic socket_supply_ctl0_in,
    input wire logic socket_supply_ctl1_in,
    input wire logic eeprom_scl_in,
    input wire logic eeprom_sda_drive_low_in,
    output logic eeprom_sda_sense_out,
    output logic serial_mode_out,
    input wire logic [6:0] multi_pin_in,
    output logic [6:0] multi_pin_out,
    output logic [6:0] multi_pin_oe_out,
    output logic [4:0] gp_input_out
);
    import terminal_router_pkg::*;

    typedef struct packed
    {
        logic [27:0] route;
        logic [`SYNC_W-1:0] s1;
        logic [`SYNC_W-1:0] s2;
        logic [`SYNC_W-1:0] s3;
        logic [`SYNC_W-1:0] filt;
        logic [6:0] pin_out;
        logic [6:0] pin_oe;
        logic [4:0] gp_in;
        logic [31:0] rdata;
        logic sda_sense;
        logic serial;
    } state_s;

    state_s st;
    state_s next_st;
    pin_drv_s drv [`ROUTE_PIN_COUNT];

    ////////////////////////////////////////////////////////////////////////
    // per-terminal selection
    function automatic pin_drv_s route_pin(input int pin, input logic [3:0] code, input src_s s,
                                           input logic ri_en);
        pin_drv_s d;
        d = '{oe: 1'b0, val: 1'b0};
        if (pin == 3 || pin == 6)
        begin
            if (code[3])
                d = '{oe: 1'b1, val: s.irq[code]};
        end
        else
        begin
            case (code)
                `CODE_GPI: d = '{oe: 1'b0, val: 1'b0};
                `CODE_GPO:
                begin
                    if (pin == 0)
                        d = '{oe: 1'b1, val: s.gp_output_zero};
                    else if (pin == 1)
                        d = '{oe: 1'b1, val: s.gp_output_one};
                    else if (pin == 4)
                        d = '{oe: 1'b1, val: s.gp_output_three};
                end
                `CODE_LOW_OR_INTA:
                begin
                    if (pin == 0)
                        d = '{oe: 1'b1, val: s.inta};
                    else if (pin == 1)
                        d = '{oe: 1'b1, val: s.low_power_state_flag};
                    else if (pin == 4)
                        d = '{oe: 1'b1, val: s.bus_lock};
                end
                4'h3: if (pin < 2) d = '{oe: 1'b1, val: s.irq[3]};
                4'h4, 4'h5: if (pin < 2 || pin == 4) d = '{oe: 1'b1, val: s.irq[code]};
                `CODE_VIDEO_STAT: if (pin < 2 || pin == 4) d = '{oe: 1'b1, val: s.video_port_status};
                `CODE_VIDEO_SEL: if (pin < 2) d = '{oe: 1'b1, val: s.video_port_select0};
                `CODE_AUDIO_PWM: d = '{oe: 1'b1, val: s.card_audio_pwm};
                4'h9, 4'hA: d = '{oe: 1'b1, val: s.irq[code]};
                4'hB: if (pin != 4) d = '{oe: 1'b1, val: s.irq[11]};
                `CODE_LED_OR_RING:
                begin
                    if (pin == 2 || pin == 4)
                    begin
                        if (ri_en)
                            d = '{oe: 1'b1, val: s.ring_indicate_out};
                    end
                    else
                        d = '{oe: 1'b1, val: s.socket_activity_led};
                end
                `CODE_LED_P4:
                begin
                    if (pin == 4)
                        d = '{oe: 1'b1, val: s.socket_activity_led};
                    else if (pin == 5)
                        d = '{oe: 1'b1, val: s.diag_test};
                    else if (pin == 2)
                        d = '{oe: 1'b1, val: s.low_power_state_flag};
                    else
                        d = '{oe: 1'b1, val: s.irq[13]};
                end
                `CODE_EVENT: d = '{oe: 1'b1, val: s.general_purpose_event};
                `CODE_LAST:
                begin
                    if (pin == 2)
                        d = '{oe: 1'b1, val: s.irq[7]};
                    else if (pin != 4)
                        d = '{oe: 1'b1, val: s.irq[15]};
                end
                default: d = '{oe: 1'b0, val: 1'b0};
            endcase
        end
        return d;
    endfunction

    genvar gi;
    generate
        for (gi = 0; gi < `ROUTE_PIN_COUNT; gi++)
        begin : g_pin
            always_comb
            begin
                drv[gi] = route_pin(gi, st.route[gi*`ROUTE_FIELD_W +: `ROUTE_FIELD_W], internal_src_in,
                                    ring_output_enable_in);
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // next state
    logic [`SYNC_W-1:0] raw;
    logic cfg_hit;
    assign raw = {socket_supply_ctl1_in, socket_supply_ctl0_in, multi_pin_in};
    assign cfg_hit = cfg_req_in.addr == `ROUTE_SEL_OFFSET;

    always_comb
    begin
        next_st = st;
        next_st.s1 = raw;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        for (int i = 0; i < `SYNC_W; i++)
        begin
            if (st.s2[i] == st.s3[i])
                next_st.filt[i] = st.s3[i];
        end
        next_st.serial = st.filt[`SUPPLY0_BIT] & st.filt[`SUPPLY1_BIT];
        if (eeprom_load_valid_in)
            next_st.route = eeprom_load_data_in[27:0];
        if (cfg_req_in.wr && cfg_hit)
        begin
            for (int b = 0; b < 4; b++)
            begin
                if (cfg_req_in.byte_en[b])
                begin
                    if (b == 3)
                        next_st.route[27:24] = cfg_req_in.wdata[27:24];
                    else
                        next_st.route[b*8 +: 8] = cfg_req_in.wdata[b*8 +: 8];
                end
            end
        end
        next_st.rdata = '0;
        if (cfg_req_in.rd && cfg_hit)
            next_st.rdata = {4'h0, st.route};
        for (int p = 0; p < `ROUTE_PIN_COUNT; p++)
        begin
            next_st.pin_oe[p] = drv[p].oe;
            next_st.pin_out[p] = drv[p].val;
        end
        if (st.serial)
        begin
            next_st.pin_oe[4] = 1'b1;
            next_st.pin_out[4] = eeprom_scl_in;
            next_st.pin_oe[1] = eeprom_sda_drive_low_in;
            next_st.pin_out[1] = 1'b0;
        end
        next_st.sda_sense = st.filt[1];
        next_st.gp_in = {st.filt[5], st.filt[4], st.filt[2], st.filt[1], st.filt[0]};
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            st <= '0;
            st.route <= `ROUTE_SEL_RESET;
        end
        else
            st <= next_st;
    end

    assign cfg_rdata_out = st.rdata;
    assign eeprom_sda_sense_out = st.sda_sense;
    assign serial_mode_out = st.serial;
    assign multi_pin_out = st.pin_out;
    assign multi_pin_oe_out = st.pin_oe;
    assign gp_input_out = st.gp_in;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    sequence s_load;
        eeprom_load_valid_in && !(cfg_req_in.wr && cfg_hit);
    endsequence
    sequence s_read;
        cfg_req_in.rd && cfg_hit;
    endsequence

    a_eeprom_load_taken: assert property (s_load |=> st.route == $past(eeprom_load_data_in[27:0]))
        else $error("eeprom value not loaded");
    a_top_bits_zero: assert property (s_read |=> cfg_rdata_out[31:28] == 4'h0
        && cfg_rdata_out[27:0] == $past(st.route)) else $error("routing readback wrong");
    a_pin6_irq_route: assert property (st.route[27] |=> multi_pin_oe_out[6]
        && multi_pin_out[6] == $past(internal_src_in.irq[{1'b1, st.route[26:24]}])) else $error("pin six irq");
    a_pin3_reserved_idle: assert property (!st.route[15] |=> !multi_pin_oe_out[3])
        else $error("pin three driven on reserved code");
    a_pin5_pwm_route: assert property (st.route[23:20] == `CODE_AUDIO_PWM |=> multi_pin_oe_out[5]
        && multi_pin_out[5] == $past(internal_src_in.card_audio_pwm)) else $error("pin five pwm");
    a_pin4_scl_mode: assert property (st.serial |=> multi_pin_oe_out[4]
        && multi_pin_out[4] == $past(eeprom_scl_in)) else $error("scl not on pin four");
    a_ring_gate_off: assert property (st.route[11:8] == `CODE_LED_OR_RING && !ring_output_enable_in
        |=> !multi_pin_oe_out[2]) else $error("ring routed while disabled");
    a_pin2_flag_route: assert property (st.route[11:8] == `CODE_LED_P4 |=> multi_pin_oe_out[2]
        && multi_pin_out[2] == $past(internal_src_in.low_power_state_flag)) else $error("pin two flag");
    a_pin1_zvsel_route: assert property (!st.serial && st.route[7:4] == `CODE_VIDEO_SEL
        |=> multi_pin_out[1] == $past(internal_src_in.video_port_select0)) else $error("pin one select");
    a_pin0_gpi_idle: assert property (st.route[3:0] == `CODE_GPI [*2] |-> !multi_pin_oe_out[0])
        else $error("pin zero driven as input");
    a_pin0_inta_route: assert property (st.route[3:0] == `CODE_LOW_OR_INTA |=> multi_pin_oe_out[0]
        && multi_pin_out[0] == $past(internal_src_in.inta)) else $error("pin zero inta");
    a_pin4_lock_route: assert property (!st.serial && st.route[19:16] == `CODE_LOW_OR_INTA
        |=> multi_pin_out[4] == $past(internal_src_in.bus_lock)) else $error("pin four lock");
endmodule // terminal_router

// ### verification/board_lines.sv
// board model: resolves the seven multifunction terminals
// assumes the bench supplies the board's own levels
module board_lines
(
    input wire logic [6:0] oe_in,
    input wire logic [6:0] drive_in,
    input wire logic [6:0] board_level_in,
    output logic [6:0] pin_out
);
    timeunit 1ns;
    timeprecision 1ns;
    ////////////////////////////////////////////////////////////
    // device drives where enabled, board level elsewhere
    always_comb
    begin
        pin_out = (oe_in & drive_in) | (~oe_in & board_level_in);
    end
endmodule // board_lines

// ### verification/multifunction_terminal_router_tb.sv
// bench: config port, routing codes, eeprom load, serial straps
// assumes design package, regs header and board_lines compiled first
module multifunction_terminal_router_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import terminal_router_pkg::*;
    typedef struct {int kind; logic [31:0] exp;} note_s;
    logic clk_in = 0, rst_in = 1, ld_v = 0, ren = 0, s0 = 0, s1 = 0, scl = 0, sda_low = 0, smode, sense;
    cfg_req_s req = '0;
    src_s src = '0;
    logic [31:0] rdata, ld_data = '0, lfsr = 32'h0000_8950;
    logic [6:0] pin, pout, poe, lvl = 7'h7F;
    logic [4:0] gpi;
    int n_fail = 0, n_compared = 0;
    note_s notes[$];
    event ev;
    terminal_router dut (.clk_in(clk_in), .rst_in(rst_in), .cfg_req_in(req), .cfg_rdata_out(rdata),
        .eeprom_load_valid_in(ld_v), .eeprom_load_data_in(ld_data), .internal_src_in(src),
        .ring_output_enable_in(ren), .socket_supply_ctl0_in(s0), .socket_supply_ctl1_in(s1),
        .eeprom_scl_in(scl), .eeprom_sda_drive_low_in(sda_low), .eeprom_sda_sense_out(sense),
        .serial_mode_out(smode), .multi_pin_in(pin), .multi_pin_out(pout), .multi_pin_oe_out(poe),
        .gp_input_out(gpi));
    board_lines board (.oe_in(poe), .drive_in(pout), .board_level_in(lvl), .pin_out(pin));
    ////////////////////////////////////////////////////////////
    // clock, random source, comparison and closing
    initial
    begin
        forever #25 clk_in = ~clk_in;
    end
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    // drivers; rd and route each note the expected result
    task automatic note(int kind, logic [31:0] exp);
        notes.push_back('{kind, exp});
        ->ev;
        @(negedge clk_in);
    endtask
    task automatic cfg(logic w, logic [7:0] a, logic [31:0] d);
        req = '{addr: a, byte_en: 4'hF, wr: w, rd: ~w, wdata: d};
        @(negedge clk_in);
        req.wr = 0;
        req.rd = 0;
        if (w)
            @(negedge clk_in);
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] exp);
        cfg(0, a, 32'h0000_0000);
        note(0, exp);
    endtask
    task automatic route(int p, int c, int i);
        logic [31:0] r;
        logic [28:0] sv;
        logic drv;
        r = rnd();
        src = r[28:0];
        ren = ~ren;
        cfg(1, 8'h8C, 32'(c) << (4 * p));
        repeat (3) @(negedge clk_in);
        sv = src;
        drv = (i != 31) && !(i == 1 && !ren);
        note(1, {18'h0, 7'(drv) << p, 7'(drv & sv[i]) << p});
    endtask
    ////////////////////////////////////////////////////////////
    // monitor: oldest note against what the outputs show
    initial
    begin
        note_s n;
        forever
        begin
            @ev;
            n = notes.pop_front();
            case (n.kind)
                0: check("rdata", rdata, n.exp);
                1: check("pins", {18'h0, poe, pout & poe}, n.exp);
                2: check("gp_input", {27'h0, gpi}, n.exp);
                default: check("serial", {26'h0, smode, poe[4], pout[4] & poe[4], poe[1], pout[1] & poe[1], sense},
                    n.exp);
            endcase
        end
    end
    initial
    begin
        repeat (20000) @(posedge clk_in);
        n_fail++;
        wrap_up();
    end
    ////////////////////////////////////////////////////////////
    // main sequence; routing programmed once per case as at power-on
    initial
    begin
        int t[30][3] = '{'{5,0,31}, '{5,8,7}, '{5,9,22}, '{5,12,6}, '{5,13,0}, '{5,14,5}, '{5,15,28},
            '{4,1,9}, '{4,2,8}, '{4,4,17}, '{4,6,4}, '{4,12,1}, '{4,13,6}, '{4,3,31}, '{2,13,2},
            '{2,15,20}, '{2,12,1}, '{2,1,31}, '{1,2,2}, '{1,7,3}, '{1,13,26}, '{1,0,31}, '{0,2,12},
            '{0,1,11}, '{0,3,16}, '{6,0,31}, '{6,7,31}, '{3,5,31}, '{4,12,1}, '{2,12,1}};
        repeat (8) @(negedge clk_in);
        rst_in = 0;
        @(negedge clk_in);
        rd(8'h8C, 32'h0000_0000);
        note(1, 32'h0000_0000);
        lvl = 7'(rnd());
        repeat (6) @(negedge clk_in);
        note(2, {lvl[5], lvl[4], lvl[2], lvl[1], lvl[0]});
        cfg(1, 8'h8C, 32'hFFFF_FFFF);
        rd(8'h8C, 32'h0FFF_FFFF);
        cfg(1, 8'h90, 32'h0000_0000);
        rd(8'h8C, 32'h0FFF_FFFF);
        rd(8'h90, 32'h0000_0000);
        ld_data = rnd();
        ld_v = 1;
        @(negedge clk_in);
        ld_v = 0;
        rd(8'h8C, {4'h0, ld_data[27:0]});
        foreach (t[k])
            route(t[k][0], t[k][1], t[k][2]);
        for (int k = 0; k < 8; k++)
        begin
            route(6, 8 + k, 21 + k);
            route(3, 8 + k, 21 + k);
        end
        cfg(1, 8'h8C, 32'h0000_0000);
        lvl = 7'h7F;
        {s0, s1, scl, sda_low} = 4'hF;
        repeat (12) @(negedge clk_in);
        note(3, 32'h0000_003C);
        {scl, sda_low} = 2'h0;
        repeat (12) @(negedge clk_in);
        note(3, 32'h0000_0031);
        wrap_up();
    end
endmodule // multifunction_terminal_router_tb
